/* File: design/esq_pkg.sv */
package esq_pkg;
  // Serial frame layout: opcode byte first, then a three-byte address.
  localparam int         FRAME_BITS      = 32;
  localparam int         OPC_W           = 8;
  localparam int         CNT_W           = 6;
  localparam logic [5:0] OPCODE_BITS     = 6'h08;
  localparam logic [5:0] ADDR_FRAME_BITS = 6'h20;
  localparam logic [5:0] BITS_SATURATE   = 6'h28;
  localparam logic [5:0] SPI_STEP        = 6'h01;
  localparam logic [5:0] QUAD_STEP       = 6'h04;
  localparam int         IO_W            = 4;

  // Array geometry: 4K sectors, eight per 32K half block, sixteen per 64K block.
  localparam int SECTOR_LSB   = 12;
  localparam int BLOCK_LSB    = 16;
  localparam int HALF_SEC_W   = 3;
  localparam int BLOCK_SEC_W  = 4;
  localparam int SEC_PER_BLK  = 16;
  localparam int DEF_ADDR_W   = 24;
  localparam int MAX_ADDR_W   = 24;
  localparam int BP_W         = 4;
  localparam int TIMER_W      = 32;

  typedef enum logic [1:0] {KIND_SECTOR, KIND_HALF, KIND_BLOCK, KIND_CHIP} kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ERASE, ST_WAIT} state_t;
endpackage

/* File: design/erase_link_if.sv */
`timescale 1ns/1ps
// Carries the captured serial frame from the link clock domain to the core.
interface erase_link_if;
  logic [esq_pkg::FRAME_BITS-1:0] frameBits;
  logic [esq_pkg::CNT_W-1:0]      bitCount;
  logic                           frameOpen;
  logic                           quadMode;
  modport rx (output frameBits, output bitCount, output frameOpen, input quadMode);
  modport core (input frameBits, input bitCount, input frameOpen, output quadMode);
endinterface

/* File: design/erase_link_rx.sv */
`timescale 1ns/1ps
module erase_link_rx (
  input  wire logic                      serialClock,
  input  wire logic                      chipSelect_n,
  input  wire logic [esq_pkg::IO_W-1:0]  serialIoLines,
  erase_link_if.rx                       lnk
);
  // The lane mode is registered by the core on every core clock, so it is read here directly.
  typedef struct packed {
    logic [esq_pkg::CNT_W-1:0]      count;
    logic [esq_pkg::FRAME_BITS-1:0] bits;
  } rx_t;

  rx_t                            rx_r;
  rx_t                            rx_nxt;
  logic                           frameOpen_r;
  logic [esq_pkg::CNT_W-1:0]      step;
  logic [esq_pkg::CNT_W-1:0]      base;
  logic [esq_pkg::FRAME_BITS-1:0] baseBits;
  logic [esq_pkg::CNT_W:0]        sum;

  // The link clock stops between frames, so the frame marker is cleared by chip select itself.
  always_ff @(posedge serialClock or posedge chipSelect_n) begin
    if (chipSelect_n) begin
      frameOpen_r <= 1'b0;
    end else begin
      frameOpen_r <= 1'b1;
    end
  end

  // Shift one bit per edge in single-line mode, a nibble per edge in quad mode.
  always_comb begin
    rx_nxt   = rx_r;
    step     = lnk.quadMode ? esq_pkg::QUAD_STEP : esq_pkg::SPI_STEP; // R7
    base     = frameOpen_r ? rx_r.count : '0;
    baseBits = frameOpen_r ? rx_r.bits : '0;
    sum      = {1'b0, base} + {1'b0, step};
    rx_nxt.count = (sum > {1'b0, esq_pkg::BITS_SATURATE}) ? esq_pkg::BITS_SATURATE : sum[5:0];
    if (lnk.quadMode) begin
      rx_nxt.bits = {baseBits[esq_pkg::FRAME_BITS-5:0], serialIoLines}; // R7
    end else begin
      rx_nxt.bits = {baseBits[esq_pkg::FRAME_BITS-2:0], serialIoLines[0]}; // R8
    end
  end

  // Frame state is rebuilt at the first edge of every frame, so no reset is needed here.
  always_ff @(posedge serialClock) begin
    rx_r <= rx_nxt;
  end

  assign lnk.frameBits = rx_r.bits;
  assign lnk.bitCount  = rx_r.count;
  assign lnk.frameOpen = frameOpen_r;

  count_step_a : assert property ( // R7
    @(posedge serialClock) disable iff (chipSelect_n)
    frameOpen_r && (rx_r.count < esq_pkg::ADDR_FRAME_BITS)
    |=> rx_r.count == $past(rx_r.count) + $past(step))
    else $error("Bit count did not advance by the lane width.");

  single_line_a : assert property ( // R8
    @(posedge serialClock) disable iff (chipSelect_n)
    frameOpen_r && !lnk.quadMode
    |=> (rx_r.bits[0] == $past(serialIoLines[0])) && (rx_r.bits[3:1] == $past(rx_r.bits[2:0])))
    else $error("Upper data lines leaked into a single-line frame.");
endmodule

/* File: design/serial_flash_erase_sequencer.sv */
// Operation
// R1: Sector erase clears one 4K sector to all ones.
// R2: Every bit of the chosen region ends at logic one.
// R3: Host must send write enable before any erase command.
// R4: Sector erase picks the sector from address bit 12 upward.
// R5: Addressed erase frames are chip select low, opcode, three address bytes, release.
// R6: Addressed erase runs only if chip select rises right after the address byte.
// R7: Opcode accepted as eight single-line clocks or two quad clocks.
// R8: Single-line mode ignores the three upper data lines.
// R9: Self-timed erase starts at the chip select rise ending a valid command.
// R10: Busy flag set throughout erase; at completion busy and write-enable latch clear.
// R11: Region protected by block bits or sector protection is not erased; chip erase in block-lock mode ignores blockLockMap and erases locked blocks.
// R12: Half-block erase clears the 32K block holding the given address.
// R13: Block erase clears the 64K block holding the given address.
// R14: Chip erase is an opcode only, released exactly on its byte boundary.
// R15: Block-lock mode runs chip erase only when all block-protect bits are zero.
// R16: Sector-protection mode chip erase clears unprotected blocks, skips protected ones.
// R17: A 64K block holding any protected sector is skipped during chip erase.
// R18: Each erase kind lasts a configurable number of clock cycles.
`timescale 1ns/1ps
module serial_flash_erase_sequencer #(
  parameter int          ADDR_W              = esq_pkg::DEF_ADDR_W,
  parameter int unsigned SECTOR_ERASE_CYCLES = 200,
  parameter int unsigned HALF_ERASE_CYCLES   = 400,
  parameter int unsigned BLOCK_ERASE_CYCLES  = 800,
  parameter int unsigned CHIP_ERASE_CYCLES   = 1600,
  parameter logic [7:0]  OPC_WRITE_ENABLE    = 8'h11,
  parameter logic [7:0]  OPC_SECTOR          = 8'h12,
  parameter logic [7:0]  OPC_HALF            = 8'h13,
  parameter logic [7:0]  OPC_BLOCK           = 8'h14,
  parameter logic [7:0]  OPC_CHIP            = 8'h15
) (
  input  wire logic                                          clock,
  input  wire logic                                          reset_n,
  input  wire logic                                          serialClock,
  input  wire logic                                          chipSelect_n,
  input  wire logic [esq_pkg::IO_W-1:0]                      serialIoLines,
  input  wire logic                                          quadCommandMode,
  input  wire logic                                          protectionSchemeSelect,
  input  wire logic [esq_pkg::BP_W-1:0]                      blockProtectBits,
  input  wire logic [2**(ADDR_W-esq_pkg::BLOCK_LSB)-1:0]     blockLockMap,
  input  wire logic [2**(ADDR_W-esq_pkg::SECTOR_LSB)-1:0]    persistentSectorProtect,
  input  wire logic [2**(ADDR_W-esq_pkg::SECTOR_LSB)-1:0]    dynamicSectorProtect,
  output logic                                               writeInProgress,
  output logic                                               writeEnableLatch,
  output logic                                               eraseStrobe,
  output logic [ADDR_W-esq_pkg::SECTOR_LSB-1:0]              eraseSector,
  output logic                                               eraseRejected
);
  localparam int SW   = ADDR_W - esq_pkg::SECTOR_LSB;
  localparam int NSEC = 2**SW;

  // Refuse geometries and timings that the walk and timer cannot serve.
  if (ADDR_W <= esq_pkg::BLOCK_LSB || ADDR_W > esq_pkg::MAX_ADDR_W
      || SECTOR_ERASE_CYCLES == 0 || HALF_ERASE_CYCLES == 0
      || BLOCK_ERASE_CYCLES == 0 || CHIP_ERASE_CYCLES == 0) begin : badConfig
    $error("Unsupported address width or zero erase duration.");
  end

  typedef struct packed {
    logic                          quadHold;
    logic                          csMeta;
    logic                          csSync;
    logic                          csPrev;
    logic                          openMeta;
    logic                          openSync;
    logic                          seenOpen;
    esq_pkg::state_t               st;
    esq_pkg::kind_t                kind;
    logic [SW-1:0]                 first;
    logic [SW-1:0]                 cur;
    logic [SW-1:0]                 last;
    logic [esq_pkg::TIMER_W-1:0]   timer;
    logic                          write_in_progress;
    logic                          write_enable_latch;
    logic                          strobe;
    logic                          rejected;
    logic [SW-1:0]                 sector;
  } core_t;

  core_t                   core_r;
  core_t                   core_nxt;
  logic [NSEC-1:0]         sectorProt;
  logic                    frameEnd;
  logic [7:0]              op8;
  logic [7:0]              op32;
  logic [SW-1:0]           addrSector;
  logic                    protHere;
  logic                    skipHere;
  logic                    isAddrOp;
  esq_pkg::kind_t          addrKind;

  erase_link_if lnk ();

  erase_link_rx linkRx (
    .serialClock   (serialClock),
    .chipSelect_n  (chipSelect_n),
    .serialIoLines (serialIoLines),
    .lnk           (lnk.rx)
  );

  // True when any sector of the 64K block holding sector s is protected.
  function automatic logic blockHit(logic [NSEC-1:0] m, logic [SW-1:0] s);
    blockHit = |m[{s[SW-1:esq_pkg::BLOCK_SEC_W], {esq_pkg::BLOCK_SEC_W{1'b0}}}
                  +: esq_pkg::SEC_PER_BLK];
  endfunction

  // First or last sector of the region that an erase kind covers around sector s.
  function automatic logic [SW-1:0] regionEdge(esq_pkg::kind_t k, logic [SW-1:0] s,
                                               logic top);
    logic [SW-1:0] fill;
    fill = top ? '1 : '0;
    case (k)
      esq_pkg::KIND_SECTOR: regionEdge = s;
      esq_pkg::KIND_HALF:   regionEdge = {s[SW-1:esq_pkg::HALF_SEC_W],
                                          fill[esq_pkg::HALF_SEC_W-1:0]};
      esq_pkg::KIND_BLOCK:  regionEdge = {s[SW-1:esq_pkg::BLOCK_SEC_W],
                                          fill[esq_pkg::BLOCK_SEC_W-1:0]};
      default:              regionEdge = fill;
    endcase
  endfunction

  // Wait cycles after the sector walk; the walk itself adds one cycle per sector.
  function automatic logic [esq_pkg::TIMER_W-1:0] duration(esq_pkg::kind_t k);
    case (k)
      esq_pkg::KIND_SECTOR: duration = esq_pkg::TIMER_W'(SECTOR_ERASE_CYCLES - 1);
      esq_pkg::KIND_HALF:   duration = esq_pkg::TIMER_W'(HALF_ERASE_CYCLES - 1);
      esq_pkg::KIND_BLOCK:  duration = esq_pkg::TIMER_W'(BLOCK_ERASE_CYCLES - 1);
      default:              duration = esq_pkg::TIMER_W'(CHIP_ERASE_CYCLES - 1);
    endcase
  endfunction

  // Frame decode; the link registers are stable once chip select has been high two cycles.
  // The mode is registered here from quadCommandMode on every core clock, inside frames too, because the link clock stops
  // between frames and could not move a synchroniser of its own to a new mode in time.
  assign lnk.quadMode = core_r.quadHold;
  assign sectorProt   = persistentSectorProtect | dynamicSectorProtect;
  assign op8          = lnk.frameBits[esq_pkg::OPC_W-1:0];
  assign op32         = lnk.frameBits[esq_pkg::FRAME_BITS-1 -: esq_pkg::OPC_W];
  assign addrSector   = lnk.frameBits[ADDR_W-1:esq_pkg::SECTOR_LSB]; // R4
  assign frameEnd     = core_r.csSync && !core_r.csPrev
                        && (core_r.seenOpen || core_r.openSync); // R9
  assign isAddrOp     = (op32 == OPC_SECTOR) || (op32 == OPC_HALF) || (op32 == OPC_BLOCK);
  assign addrKind     = (op32 == OPC_SECTOR) ? esq_pkg::KIND_SECTOR :
                        (op32 == OPC_HALF) ? esq_pkg::KIND_HALF : esq_pkg::KIND_BLOCK;
  assign protHere     = protectionSchemeSelect ? sectorProt[core_r.cur]
                        : blockLockMap[core_r.cur[SW-1:esq_pkg::BLOCK_SEC_W]]; // R11
  assign skipHere     = (core_r.kind == esq_pkg::KIND_CHIP) && protectionSchemeSelect
                        && blockHit(sectorProt, core_r.cur); // R17

  // Next-state logic: command acceptance, protection check, sector walk and erase timer.
  always_comb begin
    core_nxt          = core_r;
    core_nxt.strobe   = 1'b0;
    core_nxt.rejected = 1'b0;
    core_nxt.quadHold = quadCommandMode;
    core_nxt.csMeta   = chipSelect_n;
    core_nxt.csSync   = core_r.csMeta;
    core_nxt.csPrev   = core_r.csSync;
    core_nxt.openMeta = lnk.frameOpen;
    core_nxt.openSync = core_r.openMeta;
    if (core_r.openSync) begin
      core_nxt.seenOpen = 1'b1;
    end
    if (frameEnd) begin
      core_nxt.seenOpen = 1'b0;
    end
    case (core_r.st)
      esq_pkg::ST_IDLE: begin
        if (frameEnd && lnk.bitCount == esq_pkg::OPCODE_BITS) begin // R14
          if (op8 == OPC_WRITE_ENABLE) begin
            core_nxt.write_enable_latch = 1'b1; // R3
          end else if (op8 == OPC_CHIP) begin
            if (!core_r.write_enable_latch || (!protectionSchemeSelect && blockProtectBits != '0)) begin
              core_nxt.rejected = 1'b1; // R15
            end else begin
              core_nxt.kind  = esq_pkg::KIND_CHIP; // R16
              core_nxt.first = '0;
              core_nxt.cur   = '0;
              core_nxt.last  = '1;
              core_nxt.st    = esq_pkg::ST_ERASE; // R9
              core_nxt.write_in_progress   = 1'b1; // R10
            end
          end
        end else if (frameEnd && lnk.bitCount == esq_pkg::ADDR_FRAME_BITS && isAddrOp) begin // R6
          if (!core_r.write_enable_latch) begin
            core_nxt.rejected = 1'b1; // R3
          end else begin
            core_nxt.kind  = addrKind;
            core_nxt.first = regionEdge(addrKind, addrSector, 1'b0); // R12
            core_nxt.cur   = regionEdge(addrKind, addrSector, 1'b0); // R13
            core_nxt.last  = regionEdge(addrKind, addrSector, 1'b1); // R4
            core_nxt.st    = esq_pkg::ST_CHECK; // R9
            core_nxt.write_in_progress   = 1'b1; // R10
          end
        end
      end
      esq_pkg::ST_CHECK: begin
        if (protHere) begin
          core_nxt.st       = esq_pkg::ST_IDLE; // R11
          core_nxt.write_in_progress      = 1'b0;
          core_nxt.rejected = 1'b1;
        end else if (core_r.cur == core_r.last) begin
          core_nxt.cur = core_r.first;
          core_nxt.st  = esq_pkg::ST_ERASE;
        end else begin
          core_nxt.cur = core_r.cur + 1'b1;
        end
      end
      esq_pkg::ST_ERASE: begin
        if (!skipHere) begin
          core_nxt.strobe = 1'b1; // R2
          core_nxt.sector = core_r.cur; // R1
        end
        if (core_r.cur == core_r.last) begin
          core_nxt.st    = esq_pkg::ST_WAIT;
          core_nxt.timer = duration(core_r.kind); // R18
        end else begin
          core_nxt.cur = core_r.cur + 1'b1;
        end
      end
      esq_pkg::ST_WAIT: begin
        if (core_r.timer == '0) begin
          core_nxt.st  = esq_pkg::ST_IDLE;
          core_nxt.write_in_progress = 1'b0; // R10
          core_nxt.write_enable_latch = 1'b0; // R10
        end else begin
          core_nxt.timer = core_r.timer - 1'b1;
        end
      end
      default: begin
        core_nxt.st = esq_pkg::ST_IDLE;
      end
    endcase
  end

  // All core state is registered here; reset clears it to idle with the latch low.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      core_r <= '0;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign writeInProgress  = core_r.write_in_progress;
  assign writeEnableLatch = core_r.write_enable_latch;
  assign eraseStrobe      = core_r.strobe;
  assign eraseSector      = core_r.sector;
  assign eraseRejected    = core_r.rejected;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  busy_flag_a : assert property ( // R10
    core_r.write_in_progress == (core_r.st != esq_pkg::ST_IDLE))
    else $error("Busy flag disagrees with the sequencer state.");

  finish_clear_a : assert property ( // R10
    (core_r.st == esq_pkg::ST_WAIT) && (core_r.timer == '0)
    |=> !core_r.write_in_progress && !core_r.write_enable_latch)
    else $error("Busy or latch still set after erase completion.");

  start_edge_a : assert property ( // R9
    (core_r.st == esq_pkg::ST_IDLE) ##1 (core_r.st != esq_pkg::ST_IDLE) |-> $past(frameEnd))
    else $error("Erase started without a chip select rise.");

  sector_pick_a : assert property ( // R4
    frameEnd && (core_r.st == esq_pkg::ST_IDLE) && core_r.write_enable_latch
    && (lnk.bitCount == esq_pkg::ADDR_FRAME_BITS) && (op32 == OPC_SECTOR)
    |=> (core_r.cur == $past(addrSector)) && (core_r.last == core_r.cur))
    else $error("Sector erase picked the wrong sector.");

  half_span_a : assert property ( // R12
    (core_r.st == esq_pkg::ST_CHECK) && (core_r.kind == esq_pkg::KIND_HALF)
    |-> (core_r.first[esq_pkg::HALF_SEC_W-1:0] == '0)
        && (core_r.last[esq_pkg::HALF_SEC_W-1:0] == '1)
        && (core_r.first[SW-1:esq_pkg::HALF_SEC_W] == core_r.last[SW-1:esq_pkg::HALF_SEC_W]))
    else $error("Half-block erase region is misaligned.");

  block_span_a : assert property ( // R13
    (core_r.st == esq_pkg::ST_CHECK) && (core_r.kind == esq_pkg::KIND_BLOCK)
    |-> (core_r.first[esq_pkg::BLOCK_SEC_W-1:0] == '0)
        && (core_r.last[esq_pkg::BLOCK_SEC_W-1:0] == '1)
        && (core_r.first[SW-1:esq_pkg::BLOCK_SEC_W] == core_r.last[SW-1:esq_pkg::BLOCK_SEC_W]))
    else $error("Block erase region is misaligned.");

  protect_stop_a : assert property ( // R11
    (core_r.st == esq_pkg::ST_CHECK) && protHere
    |=> (core_r.st == esq_pkg::ST_IDLE) && core_r.rejected && !core_r.strobe)
    else $error("Protected region was not refused.");

  exact_edge_a : assert property ( // R6
    frameEnd && (core_r.st == esq_pkg::ST_IDLE)
    && (lnk.bitCount != esq_pkg::ADDR_FRAME_BITS) && (lnk.bitCount != esq_pkg::OPCODE_BITS)
    |=> (core_r.st == esq_pkg::ST_IDLE) && !core_r.write_in_progress)
    else $error("Frame off a byte boundary started an erase.");

  chip_lock_a : assert property ( // R15
    frameEnd && (core_r.st == esq_pkg::ST_IDLE) && (lnk.bitCount == esq_pkg::OPCODE_BITS)
    && (op8 == OPC_CHIP) && !protectionSchemeSelect && (blockProtectBits != '0)
    |=> (core_r.st == esq_pkg::ST_IDLE) && !core_r.write_in_progress)
    else $error("Chip erase ran with block-protect bits set.");

  block_skip_a : assert property ( // R17
    (core_r.st == esq_pkg::ST_ERASE) && skipHere |=> !core_r.strobe)
    else $error("Sector of a protected block was erased.");

  strobe_ones_a : assert property ( // R2
    (core_r.st == esq_pkg::ST_ERASE) && !skipHere
    |=> core_r.strobe && (core_r.sector == $past(core_r.cur)))
    else $error("Walked sector was not erased.");

  wait_time_a : assert property ( // R18
    $rose(core_r.st == esq_pkg::ST_WAIT) |-> core_r.timer == duration(core_r.kind))
    else $error("Erase timer loaded with the wrong duration.");
endmodule

/* File: verif/flash_host_model.sv */
`timescale 1ns/1ps
// Behavioural host controller that frames commands on the serial link.
module flash_host_model (
  output logic       serialClock,
  output logic       chipSelect_n,
  output logic [3:0] serialIoLines
);
  // The link clock idles low and runs only inside a frame.
  initial begin
    serialClock = 1'b0;
    chipSelect_n = 1'b0;
    serialIoLines = 4'hA;
    // A rising chip select after time zero is sure to clear the link frame flag.
    #1 chipSelect_n = 1'b1;
  end

  // Shifts nBits of word out MSB first, one bit or one nibble per link clock.
  task automatic sendFrame(input logic [31:0] word, input int nBits, input logic quad);
    chipSelect_n = 1'b0;
    for (int i = 0; i < nBits; i += (quad ? 4 : 1)) begin
      if (quad) begin
        serialIoLines = word[31-i -: 4];
      end else begin
        serialIoLines = {~serialIoLines[3:1], word[31-i]};
      end
      #6 serialClock = 1'b1;
      #6 serialClock = 1'b0;
    end
    #3 chipSelect_n = 1'b1;
    // Released lines must not keep showing the last bit.
    serialIoLines = ~serialIoLines;
  endtask
endmodule

/* File: verif/serial_flash_erase_sequencer_tb_top.sv */
`timescale 1ns/1ps
module serial_flash_erase_sequencer_tb_top;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h11;
  localparam logic [7:0] OP_SEC  = 8'h12;
  localparam logic [7:0] OP_HALF = 8'h13;
  localparam logic [7:0] OP_BLK  = 8'h14;
  localparam logic [7:0] OP_CHIP = 8'h15;
  localparam int         SEC_CYC = 20;

  logic        clock;
  logic        reset_n;
  logic        serialClock;
  logic        chipSelect_n;
  logic [3:0]  serialIoLines;
  logic        quadCommandMode;
  logic        protectionSchemeSelect;
  logic [3:0]  blockProtectBits;
  logic [1:0]  blockLockMap;
  logic [31:0] persistentSectorProtect;
  logic [31:0] dynamicSectorProtect;
  logic        writeInProgress;
  logic        writeEnableLatch;
  logic        eraseStrobe;
  logic [4:0]  eraseSector;
  logic        eraseRejected;
  logic [4:0]  firstSec;
  logic [4:0]  lastSec;
  logic        wipEarly;
  int          strobeCount;
  int          rejectCount;
  int          busyCount;
  int          miscompares;
  int          compares;

  // Seventeen address bits give 32 sectors in two 64K blocks.
  serial_flash_erase_sequencer #(.ADDR_W(17), .SECTOR_ERASE_CYCLES(SEC_CYC),
    .HALF_ERASE_CYCLES(30), .BLOCK_ERASE_CYCLES(40), .CHIP_ERASE_CYCLES(50),
    .OPC_WRITE_ENABLE(OP_WRITE_ENABLE_CMD), .OPC_SECTOR(OP_SEC), .OPC_HALF(OP_HALF),
    .OPC_BLOCK(OP_BLK), .OPC_CHIP(OP_CHIP)) dut (.clock(clock), .reset_n(reset_n),
    .serialClock(serialClock), .chipSelect_n(chipSelect_n), .serialIoLines(serialIoLines),
    .quadCommandMode(quadCommandMode), .protectionSchemeSelect(protectionSchemeSelect),
    .blockProtectBits(blockProtectBits), .blockLockMap(blockLockMap),
    .persistentSectorProtect(persistentSectorProtect),
    .dynamicSectorProtect(dynamicSectorProtect), .writeInProgress(writeInProgress),
    .writeEnableLatch(writeEnableLatch), .eraseStrobe(eraseStrobe),
    .eraseSector(eraseSector), .eraseRejected(eraseRejected));

  flash_host_model host (.serialClock(serialClock), .chipSelect_n(chipSelect_n),
    .serialIoLines(serialIoLines));

  // Core clock of 5 ns.
  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // Records strobes, refusals and busy cycles of the current operation.
  always @(posedge clock) begin
    if (eraseStrobe === 1'b1) begin
      if (strobeCount == 0) firstSec = eraseSector;
      lastSec = eraseSector;
      strobeCount++;
    end
    if (eraseRejected === 1'b1) rejectCount++;
    if (writeInProgress === 1'b1) busyCount++;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic setProt(input logic sel, input logic [3:0] bp, input logic [1:0] lock,
                         input logic [31:0] pers, input logic [31:0] dyn);
    @(posedge clock);
    #1;
    protectionSchemeSelect = sel;
    blockProtectBits = bp;
    blockLockMap = lock;
    persistentSectorProtect = pers;
    dynamicSectorProtect = dyn;
  endtask

  // Sends one frame, then waits a bounded time for the device to go idle.
  task automatic runOp(input logic [7:0] opc, input logic [23:0] addr, input int nBits);
    strobeCount = 0;
    rejectCount = 0;
    busyCount = 0;
    @(posedge clock);
    #1;
    host.sendFrame({opc, addr}, nBits, quadCommandMode);
    repeat (6) @(posedge clock);
    wipEarly = writeInProgress;
    for (int i = 0; i < 4000 && writeInProgress !== 1'b0; i++) @(posedge clock);
    repeat (4) @(posedge clock);
  endtask

  task automatic expectOp(input int n, input logic [4:0] first, input logic [4:0] last,
                          input int rej, input logic latch);
    check("strobes", n, strobeCount);
    if (n > 0) check("first sector", first, firstSec);
    if (n > 0) check("last sector", last, lastSec);
    check("refusals", rej, rejectCount);
    check("latch", latch, writeEnableLatch);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short after far longer than the sequence needs.
  initial begin
    #300000;
    miscompares++;
    complete_run;
  end

  initial begin
    miscompares = 0;
    compares = 0;
    reset_n = 1'b0;
    quadCommandMode = 1'b0;
    protectionSchemeSelect = 1'b0;
    blockProtectBits = 4'h0;
    blockLockMap = 2'h0;
    persistentSectorProtect = 32'h0;
    dynamicSectorProtect = 32'h0;
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
    check("idle busy", 0, writeInProgress);
    runOp(OP_SEC, 24'h013456, 32);
    expectOp(0, 5'h0, 5'h0, 1, 1'b0);
    runOp(OP_WRITE_ENABLE_CMD, 24'h0, 8);
    runOp(OP_SEC, 24'h013456, 32);
    expectOp(1, 5'h13, 5'h13, 0, 1'b0);
    check("busy at start", 1, wipEarly);
    check("busy long", 1, busyCount >= SEC_CYC);
    @(posedge clock);
    #1 quadCommandMode = 1'b1;
    runOp(OP_WRITE_ENABLE_CMD, 24'h0, 8);
    runOp(OP_HALF, 24'h009ABC, 32);
    expectOp(8, 5'h08, 5'h0F, 0, 1'b0);
    @(posedge clock);
    #1 quadCommandMode = 1'b0;
    runOp(OP_WRITE_ENABLE_CMD, 24'h0, 8);
    runOp(OP_BLK, 24'h01FFFF, 32);
    expectOp(16, 5'h10, 5'h1F, 0, 1'b0);
    runOp(OP_WRITE_ENABLE_CMD, 24'h0, 8);
    runOp(OP_SEC, 24'h013456, 31);
    expectOp(0, 5'h0, 5'h0, 0, 1'b1);
    runOp(OP_CHIP, 24'h0, 9);
    expectOp(0, 5'h0, 5'h0, 0, 1'b1);
    setProt(1'b0, 4'h0, 2'b10, 32'h0, 32'h0);
    runOp(OP_SEC, 24'h010000, 32);
    expectOp(0, 5'h0, 5'h0, 1, 1'b1);
    setProt(1'b1, 4'h0, 2'b00, 32'h8, 32'h0);
    runOp(OP_HALF, 24'h000000, 32);
    expectOp(0, 5'h0, 5'h0, 1, 1'b1);
    setProt(1'b0, 4'h1, 2'b00, 32'h0, 32'h0);
    runOp(OP_CHIP, 24'h0, 8);
    expectOp(0, 5'h0, 5'h0, 1, 1'b1);
    setProt(1'b0, 4'h0, 2'b00, 32'h0, 32'h0);
    runOp(OP_CHIP, 24'h0, 8);
    expectOp(32, 5'h00, 5'h1F, 0, 1'b0);
    setProt(1'b1, 4'h0, 2'b00, 32'h0, 32'h0010_0000);
    runOp(OP_WRITE_ENABLE_CMD, 24'h0, 8);
    runOp(OP_CHIP, 24'h0, 8);
    expectOp(16, 5'h00, 5'h0F, 0, 1'b0);
    complete_run;
  end
endmodule
